// ### verilog/scan_port_regs.vh
/*
  constants for the boundary scan test port: instruction codes, widths,
  controller state codes.
  assumes inclusion by the design file, the port checker and the bench.
*/
`ifndef SCAN_PORT_REGS_VH
`define SCAN_PORT_REGS_VH

// ----------------------------------------
// instruction register
// ----------------------------------------
`define IR_WIDTH        10
`define IR_BYPASS       10'h3FF
`define IR_EXTEST       10'h00F
`define IR_SAMPLE       10'h005
`define IR_CAPTURE_VAL  10'h001

// ----------------------------------------
// boundary chain
// ----------------------------------------
`define IO_COUNT        4
`define CELL_BITS       3
`define CHAIN_LEN       12
`define CELL_OUT        0
`define CELL_OE         1
`define CELL_IN         2

// ----------------------------------------
// pin idle levels {tck, tms, tdi}
// ----------------------------------------
`define PIN_IDLE        3'h7

// ----------------------------------------
// controller states
// ----------------------------------------
`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SH_DR        4'h4
`define ST_EX1_DR       4'h5
`define ST_PAU_DR       4'h6
`define ST_EX2_DR       4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'hA
`define ST_SH_IR        4'hB
`define ST_EX1_IR       4'hC
`define ST_PAU_IR       4'hD
`define ST_EX2_IR       4'hE
`define ST_UPD_IR       4'hF

`endif

// ### verilog/boundary_testing.v
/*
  boundary scan test port: tap controller, instruction register, bypass
  register and a chain of three-bit boundary cells, one per user i/o.
  assumes the test clock is far slower than ref_clk (800 ns against 100 ns)
  so that edges are found by sampling; supply pins carry no cells.
*/
`include "scan_port_regs.vh"
`default_nettype none

module boundary_testing
(
  // clock, reset, enable
  input  wire                   ref_clk,
  input  wire                   reset,
  input  wire                   clk_en,
  // test port pins
  input  wire                   tck,
  input  wire                   tms,
  input  wire                   tdi,
  output reg                    tdo_out_ff,
  output reg                    tdo_oe_ff,
  // core side of the user pins
  input  wire [`IO_COUNT-1:0]   core_output_value,
  input  wire [`IO_COUNT-1:0]   core_output_enable,
  output reg  [`IO_COUNT-1:0]   core_input_feed_ff,
  // pad side of the user pins
  input  wire [`IO_COUNT-1:0]   pad_in,
  output reg  [`IO_COUNT-1:0]   pad_out_ff,
  output reg  [`IO_COUNT-1:0]   pad_oe_ff
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [2:0]            sync1_ff;       // first stage, read only by second
  reg [2:0]            sync2_ff;       // tck, tms, tdi stable copies
  reg                  tck_prev_ff;    // for edge detection
  reg [`IO_COUNT-1:0]  pin1_ff;        // pad input first stage
  reg [`IO_COUNT-1:0]  pin2_ff;        // pad input second stage

  // a pin edge just before ref_clk may be caught one cycle late; tms and
  // tdi ride the same two stages as tck, so they stay lined up with it
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      // pins rest high between frames, so the edge finder starts at the
      // idle level and reset release shows no false tck edge
      sync1_ff    <= `PIN_IDLE;
      sync2_ff    <= `PIN_IDLE;
      tck_prev_ff <= 1'b1;
      pin1_ff     <= {`IO_COUNT{1'b0}};
      pin2_ff     <= {`IO_COUNT{1'b0}};
    end
    else if (clk_en)
    begin
      sync1_ff    <= {tck, tms, tdi};
      sync2_ff    <= sync1_ff;
      tck_prev_ff <= sync2_ff[2];
      pin1_ff     <= pad_in;
      pin2_ff     <= pin1_ff;
    end
  end

  wire tck_s   = sync2_ff[2];          // synchronised test clock
  wire tms_s   = sync2_ff[1];          // mode select
  wire tdi_s   = sync2_ff[0];          // serial data in
  wire tck_up  = tck_s & ~tck_prev_ff;  // rising edge found
  wire tck_dn  = ~tck_s & tck_prev_ff;  // falling edge found

  // ----------------------------------------
  // shared decodes
  // ----------------------------------------
  // chain position of one stage of a pin's cell; keeping it in one place
  // stops capture and pin drive from disagreeing on the cell layout
  function integer cell_bit;
    input integer pin;                 // user pin number
    input integer slot;                // stage within the cell
    begin
      cell_bit = pin * `CELL_BITS + slot;
    end
  endfunction

  // the two states in which tdo carries data
  function is_shift;
    input [3:0] st;                    // controller state
    begin
      is_shift = (st == `ST_SH_DR) | (st == `ST_SH_IR);
    end
  endfunction

  // ----------------------------------------
  // tap controller
  // ----------------------------------------
  reg [3:0] state_ff;                  // controller state
  reg [3:0] nxt_state;

  // next state from mode select; tms rests high through its pull-up, so a
  // silent tester parks the controller in reset
  always @*
  begin
    case (state_ff)
      `ST_RESET:   nxt_state = tms_s ? `ST_RESET  : `ST_IDLE;
      `ST_IDLE:    nxt_state = tms_s ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR:  nxt_state = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR:  nxt_state = tms_s ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR:   nxt_state = tms_s ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR:  nxt_state = tms_s ? `ST_UPD_DR : `ST_PAU_DR;
      `ST_PAU_DR:  nxt_state = tms_s ? `ST_EX2_DR : `ST_PAU_DR;
      `ST_EX2_DR:  nxt_state = tms_s ? `ST_UPD_DR : `ST_SH_DR;
      `ST_UPD_DR:  nxt_state = tms_s ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR:  nxt_state = tms_s ? `ST_RESET  : `ST_CAP_IR;
      `ST_CAP_IR:  nxt_state = tms_s ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR:   nxt_state = tms_s ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR:  nxt_state = tms_s ? `ST_UPD_IR : `ST_PAU_IR;
      `ST_PAU_IR:  nxt_state = tms_s ? `ST_EX2_IR : `ST_PAU_IR;
      `ST_EX2_IR:  nxt_state = tms_s ? `ST_UPD_IR : `ST_SH_IR;
      `ST_UPD_IR:  nxt_state = tms_s ? `ST_SEL_DR : `ST_IDLE;
      default:     nxt_state = `ST_RESET;
    endcase
  end

  // ----------------------------------------
  // global controls to all cells
  // ----------------------------------------
  // decoded from the state held at the edge just found, rising for capture and shift,
  // falling for update; each strobe lasts one ref_clk, the cycle in which the edge is found
  wire in_reset  = (state_ff == `ST_RESET);
  wire cap_dr    = tck_up & (state_ff == `ST_CAP_DR);
  wire sh_dr     = tck_up & (state_ff == `ST_SH_DR);
  wire upd_dr    = tck_dn & (state_ff == `ST_UPD_DR);
  wire cap_ir    = tck_up & (state_ff == `ST_CAP_IR);
  wire sh_ir     = tck_up & (state_ff == `ST_SH_IR);
  wire upd_ir    = tck_dn & (state_ff == `ST_UPD_IR);

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  reg [`IR_WIDTH-1:0]  ir_shift_ff;    // shift stage
  reg [`IR_WIDTH-1:0]  ir_ff;          // active instruction

  // only update-ir and the reset state change the active code, so a
  // half-shifted pattern never reaches the cells
  // decodes: sel_bsr shared by capture, update and output mux, test_mode used by pin drive
  wire sel_bsr   = (ir_ff == `IR_EXTEST) | (ir_ff == `IR_SAMPLE);
  wire test_mode = (ir_ff == `IR_EXTEST);

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  reg                   bypass_ff;     // one-bit bypass
  reg [`CHAIN_LEN-1:0]  chain_ff;      // capture/shift stages
  reg [`CHAIN_LEN-1:0]  upd_ff;        // update stages
  reg [`CHAIN_LEN-1:0]  cap_val;       // parallel capture value
  integer               i;             // capture loop index
  integer               j;             // pin drive loop index

  // cell i holds {pad input, output enable, output}; bit 0 nearest tdo,
  // cells only exist for user pins so supply pins add nothing
  always @*
  begin
    cap_val = {`CHAIN_LEN{1'b0}};
    for (i = 0; i < `IO_COUNT; i = i + 1)
    begin
      cap_val[cell_bit(i, `CELL_OUT)] = core_output_value[i];
      cap_val[cell_bit(i, `CELL_OE)]  = core_output_enable[i];
      cap_val[cell_bit(i, `CELL_IN)]  = pin2_ff[i];
    end
  end

  // controller, instruction and data register state on the test clock edges;
  // nothing here looks at configuration, so scan works at any time
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff    <= `ST_RESET;
      ir_shift_ff <= {`IR_WIDTH{1'b0}};
      ir_ff       <= `IR_BYPASS;
      bypass_ff   <= 1'b0;
      chain_ff    <= {`CHAIN_LEN{1'b0}};
      upd_ff      <= {`CHAIN_LEN{1'b0}};
    end
    else if (clk_en)
    begin
      // mode select taken only on a rising edge
      if (tck_up)
        state_ff <= nxt_state;
      // instruction path; capture-ir loads a fixed pattern so a broken
      // instruction chain shows up at the tester
      if (cap_ir)
        ir_shift_ff <= `IR_CAPTURE_VAL;
      else if (sh_ir)
        ir_shift_ff <= {tdi_s, ir_shift_ff[`IR_WIDTH-1:1]};
      if (in_reset)
        ir_ff <= `IR_BYPASS;          // reset state leaves bypass selected
      else if (upd_ir)
        ir_ff <= ir_shift_ff;
      // bypass: captures zero, shifts one bit; it captures even when the
      // chain is selected, harmless since only one path reaches tdo
      if (cap_dr)
        bypass_ff <= 1'b0;
      else if (sh_dr)
        bypass_ff <= tdi_s;
      // boundary chain only moves when selected
      if (sel_bsr & cap_dr)
        chain_ff <= cap_val;
      else if (sel_bsr & sh_dr)
        chain_ff <= {tdi_s, chain_ff[`CHAIN_LEN-1:1]};
      // update on the falling edge in update-dr, a tck and a half after the last shift, so the
      // pins never show a partly shifted pattern
      if (sel_bsr & upd_dr)
        upd_ff <= chain_ff;
    end
  end

  // ----------------------------------------
  // serial output, launched on falling edge
  // ----------------------------------------
  reg nxt_tdo;

  // pick the stage nearest the output for the active path
  always @*
  begin
    if (state_ff == `ST_SH_IR)
      nxt_tdo = ir_shift_ff[0];
    else if (sel_bsr)
      nxt_tdo = chain_ff[0];
    else
      nxt_tdo = bypass_ff;
  end

  // driving only in the two shift states; the tester samples it on
  // the following rising edge
  // limitation: tdo trails the pin edge by about three ref_clk, so tck
  // must stay several times slower than ref_clk
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tdo_out_ff <= 1'b0;
      tdo_oe_ff  <= 1'b0;
    end
    else if (clk_en & tck_dn)
    begin
      tdo_out_ff <= nxt_tdo;
      tdo_oe_ff  <= is_shift(state_ff);
    end
  end

  // ----------------------------------------
  // pin drive: update stages or core
  // ----------------------------------------
  // registered so every output comes from a flip-flop, one ref_clk late;
  // trade-off: one cycle of extra delay on every pin buys outputs that
  // cannot glitch while the cell mode changes
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pad_out_ff         <= {`IO_COUNT{1'b0}};
      pad_oe_ff          <= {`IO_COUNT{1'b0}};
      core_input_feed_ff <= {`IO_COUNT{1'b0}};
    end
    else if (clk_en)
    begin
      // cell mode picks the update stages or the functional core path
      for (j = 0; j < `IO_COUNT; j = j + 1)
      begin
        if (test_mode)
        begin
          // pins forced from the update stages
          pad_out_ff[j]         <= upd_ff[cell_bit(j, `CELL_OUT)];
          pad_oe_ff[j]          <= upd_ff[cell_bit(j, `CELL_OE)];
          core_input_feed_ff[j] <= upd_ff[cell_bit(j, `CELL_IN)];
        end
        else
        begin
          // functional: core drives the pads, pads feed the core
          pad_out_ff[j]         <= core_output_value[j];
          pad_oe_ff[j]          <= core_output_enable[j];
          core_input_feed_ff[j] <= pin2_ff[j];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/scan_port_monitor.sv
/* port checker for the scan test block.
   assumes tck is far slower than ref_clk and edges are found by sampling. */
`include "scan_port_regs.vh"
`default_nettype none
module scan_port_monitor (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 reset,
  // test port
  input wire logic                 tck,
  input wire logic                 tdo_out_ff,
  input wire logic                 tdo_oe_ff,
  // core and pad side
  input wire logic [`IO_COUNT-1:0] core_output_value,
  input wire logic [`IO_COUNT-1:0] core_output_enable,
  input wire logic [`IO_COUNT-1:0] pad_out_ff,
  input wire logic [`IO_COUNT-1:0] pad_oe_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // assertions, all on ref_clk
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // tdo and its enable move only while tck is low
  AST_TDO_ON_FALL: assert property (
    $changed(tdo_out_ff) |-> !$past(tck, 2)) else $error("tdo moved in tck high phase");
  AST_OE_RISE_ON_FALL: assert property (
    $rose(tdo_oe_ff) |-> !$past(tck, 2)) else $error("tdo enable rose in tck high phase");
  AST_OE_FALL_ON_FALL: assert property (
    $fell(tdo_oe_ff) |-> !$past(tck, 2)) else $error("tdo enable fell in tck high phase");
  // a shift lasts at least one whole tck period
  AST_OE_MIN_WIDTH: assert property (
    $rose(tdo_oe_ff) |=> tdo_oe_ff [*7]) else $error("tdo enable too short");
  // frozen tck leaves nothing for the controller to do
  AST_OE_STILL_TCK: assert property (
    $stable(tck) [*8] |-> $stable(tdo_oe_ff)) else $error("tdo enable moved with tck still");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    reset |-> !tdo_oe_ff && pad_oe_ff == '0 && pad_out_ff == '0) else $error("outputs live in reset");
  // pads follow the core, or switch at an update on falling tck
  AST_PAD_OUT_CAUSE: assert property (
    $changed(pad_out_ff) |-> pad_out_ff == $past(core_output_value) || !$past(tck, 2))
    else $error("pad output changed without cause");
  AST_PAD_OE_CAUSE: assert property (
    $changed(pad_oe_ff) |-> pad_oe_ff == $past(core_output_enable) || !$past(tck, 2))
    else $error("pad enable changed without cause");
  cover property ($rose(tdo_oe_ff));
  cover property ($fell(tdo_oe_ff));
  cover property ($changed(pad_out_ff) && !$past(tck, 2));
endmodule
bind boundary_testing scan_port_monitor scan_port_monitor_inst (.ref_clk, .reset, .tck, .tdo_out_ff,
  .tdo_oe_ff, .core_output_value, .core_output_enable, .pad_out_ff, .pad_oe_ff);
`default_nettype wire

// ### dv/scan_tester.sv
/* model of the external test controller driving the scan port.
   assumes ref_clk at 100 ns; tck made at 800 ns, still between frames. */
`default_nettype none
module scan_tester (
  // clock
  input wire logic ref_clk,
  // tester outputs
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  // device output
  input wire logic tdo_out_ff,
  input wire logic tdo_oe_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_bit; // last tdo bit seen
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    last_bit = 1'b0;
  end
  // one tck period; tdo read late in the high phase
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge ref_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // released tdo has no pull: show the inverse, never a stale value
    q = tdo_oe_ff ? tdo_out_ff : ~last_bit;
    last_bit = q;
  endtask
  // walk the controller, tms bits lsb first
  task automatic nav(input logic [7:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      step(pat[i], 1'b1, q);
  endtask
  task automatic scan(input int n, input logic [11:0] din, output logic [11:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
  endtask
  // released inputs float to their pull-ups
  task automatic rest;
    @(posedge ref_clk);
    tms <= 1'b1;
    tdi <= 1'b1;
  endtask
  task automatic ir(input logic [9:0] code, output logic [9:0] cap);
    logic [11:0] o;
    nav(8'h03, 4);
    scan(10, {2'h0, code}, o);
    cap = o[9:0];
    nav(8'h01, 2);
    rest();
  endtask
  task automatic dr(input int n, input logic [11:0] din, output logic [11:0] dout);
    nav(8'h01, 3);
    scan(n, din, dout);
    nav(8'h01, 2);
    rest();
  endtask
endmodule
`default_nettype wire

// ### dv/tb_boundary_testing.sv
/* self-checking bench for the scan test block.
   assumes scan_tester as the far side and the bound port checker. */
`include "scan_port_regs.vh"
`default_nettype none
module tb_boundary_testing;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 ref_clk, reset, clk_en, tck, tms, tdi, tdo_out_ff, tdo_oe_ff;
  logic [`IO_COUNT-1:0] core_output_value, core_output_enable, core_input_feed_ff;
  logic [`IO_COUNT-1:0] pad_in, pad_out_ff, pad_oe_ff;
  logic [11:0]          o;   // scanned-out data
  logic [9:0]           cap; // captured instruction bits
  int                   num_errors = 0, check_count = 0, cycles = 0;
  boundary_testing boundary_testing_inst (.ref_clk, .reset, .clk_en, .tck, .tms, .tdi, .tdo_out_ff,
    .tdo_oe_ff, .core_output_value, .core_output_enable, .core_input_feed_ff, .pad_in, .pad_out_ff, .pad_oe_ff);
  scan_tester scan_tester_inst (.ref_clk, .tck, .tms, .tdi, .tdo_out_ff, .tdo_oe_ff);
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard, far above the roughly 1200 cycles needed
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      num_errors++;
      complete_run();
    end
  end
  function automatic logic [11:0] cell_pack(input logic [3:0] v, input logic [3:0] e, input logic [3:0] i);
    for (int k = 0; k < 4; k++)
      cell_pack[3*k +: 3] = {i[k], e[k], v[k]};
  endfunction
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_bypass; // all-ones and an unknown code both give bypass
    logic [9:0] codes [2] = '{`IR_BYPASS, 10'h2AA};
    scan_tester_inst.nav(8'h00, 1);
    foreach (codes[n])
    begin
      scan_tester_inst.ir(codes[n], cap);
      check("ir_capture", {2'h0, cap}, {2'h0, `IR_CAPTURE_VAL});
      scan_tester_inst.dr(4, 12'h00B, o);
      check("bypass_path", o, 12'h006);
    end
  endtask
  task automatic t_sample; // snapshot of live pins plus preload
    @(posedge ref_clk);
    core_output_value <= 4'h5;
    core_output_enable <= 4'hC;
    pad_in <= 4'h9;
    scan_tester_inst.ir(`IR_SAMPLE, cap);
    scan_tester_inst.dr(12, cell_pack(4'h3, 4'h9, 4'hE), o);
    check("sample_capture", o, cell_pack(4'h5, 4'hC, 4'h9));
    check("pins_functional", {pad_oe_ff, pad_out_ff, core_input_feed_ff}, 12'hC59);
  endtask
  task automatic t_extest; // preload drives pins, then a new pattern
    scan_tester_inst.ir(`IR_EXTEST, cap);
    check("preload_driven", {pad_oe_ff, pad_out_ff, core_input_feed_ff}, 12'h93E);
    scan_tester_inst.dr(12, cell_pack(4'hA, 4'h6, 4'h3), o);
    check("extest_capture", o, cell_pack(4'h5, 4'hC, 4'h9));
    check("extest_update", {pad_oe_ff, pad_out_ff, core_input_feed_ff}, 12'h6A3);
  endtask
  task automatic t_tms_reset; // five ones from mid-shift
    scan_tester_inst.nav(8'h01, 3);
    scan_tester_inst.nav(8'h1F, 5);
    repeat (4) @(posedge ref_clk);
    check("functional_again", {pad_oe_ff, pad_out_ff, core_input_feed_ff}, 12'hC59);
    check("tdo_released", {11'h0, tdo_oe_ff}, 12'h000);
    scan_tester_inst.nav(8'h00, 1);
    scan_tester_inst.dr(2, 12'h001, o);
    check("bypass_after_reset", o, 12'h002);
  endtask
  task automatic t_pause; // shift, park in pause, resume, all in bypass
    logic [11:0] o2;
    scan_tester_inst.nav(8'h01, 3);
    scan_tester_inst.scan(2, 12'h003, o);
    scan_tester_inst.nav(8'h04, 4); // pause twice, exit2, back to shift
    scan_tester_inst.scan(2, 12'h000, o2);
    scan_tester_inst.nav(8'h01, 2);
    scan_tester_inst.rest();
    check("pause_first", o, 12'h002);
    check("pause_resume", o2, 12'h001);
  endtask
  task automatic t_freeze; // clock enable low holds every flop
    @(posedge ref_clk);
    clk_en <= 1'b0;
    core_output_value <= 4'hA;
    repeat (4) @(posedge ref_clk);
    check("frozen_pads", {8'h0, pad_out_ff}, 12'h005);
    clk_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("thawed_pads", {8'h0, pad_out_ff}, 12'h00A);
  endtask
  initial
  begin
    // non-blocking at time zero, so the reset edge reaches the design's
    // processes after they are waiting for it
    reset <= 1'b1;
    clk_en <= 1'b1;
    core_output_value <= '0;
    core_output_enable <= '0;
    pad_in <= '0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("idle_outputs", {tdo_oe_ff, pad_oe_ff, pad_out_ff, 3'h0}, 12'h000);
    t_bypass();
    t_sample();
    t_extest();
    t_tms_reset();
    t_pause();
    t_freeze();
    complete_run();
  end
endmodule
`default_nettype wire
